// *** dv/coo_charger_option_one_test.sv ***
// Self-checking bench for the charger option one register bank.
`timescale 1ns/1ns
module coo_charger_option_one_test;
    import coo_pkg::*;
    logic       ref_clk = 0, rstn = 0, clkEn = 1, lowPowerMode = 0, inputLimitPin = 1;
    coo_req_t   req;
    logic [7:0] rdData, high;
    logic       rdValid;
    logic [15:0] chargerOptionOne;
    coo_ctrl_t  ctrl, expCtrl;
    logic [7:0] expQ[$];
    int         n_mismatch = 0, n_compared = 0, cycles = 0;
    always #25 ref_clk = ~ref_clk;
    coo_host_model i_coo_host_model (.ref_clk(ref_clk), .req(req));
    coo_charger_option_one i_coo_charger_option_one (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
        .req(req), .lowPowerMode(lowPowerMode), .inputLimitPin(inputLimitPin), .rdData(rdData),
        .rdValid(rdValid), .chargerOptionOne(chargerOptionOne), .ctrl(ctrl));
    task automatic cmp(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, e);
        expQ.push_back(e);
        i_coo_host_model.access(1'b0, a, 8'h00);
    endtask
    task automatic chk;
        expCtrl = {high[7] & ~lowPowerMode, high[4] & ~lowPowerMode, high[6:5] == HOT_VSYS, high[3],
                   high[2], high[1], high[0] & ~inputLimitPin, ~high[0] & ~inputLimitPin};
        #1;
        cmp(16'(ctrl), 16'(expCtrl));
    endtask
    task print_verdict;
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(negedge ref_clk) if (rdValid === 1'b1) cmp(rdData, expQ.pop_front());
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(24));
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        cmp(chargerOptionOne, OPT1_RESET);
        high = 8'h02;
        rd(OPT1_LOW_ADDR, 8'h11);
        rd(OPT1_HIGH_ADDR, high);
        rd(8'h32, 8'h00);
        i_coo_host_model.access(1'b1, 8'h32, 8'hFF);
        chk();
        @(posedge ref_clk);
        clkEn <= 1'b0;
        i_coo_host_model.access(1'b1, OPT1_HIGH_ADDR, 8'hFF);
        clkEn <= 1'b1;
        rd(OPT1_HIGH_ADDR, high);
        repeat (60) begin
            @(posedge ref_clk);
            high = 8'($urandom);
            {lowPowerMode, inputLimitPin} <= 2'($urandom);
            i_coo_host_model.access(1'b1, OPT1_HIGH_ADDR, high);
            rd(OPT1_HIGH_ADDR, high);
            chk();
        end
        i_coo_host_model.access(1'b1, OPT1_LOW_ADDR, 8'hA5);
        rd(OPT1_LOW_ADDR, 8'hA5);
        repeat (2) @(posedge ref_clk);
        print_verdict();
    end
endmodule

// *** dv/coo_host_model.sv ***
// Host model that issues register writes and reads to the option register bank.
`timescale 1ns/1ns
module coo_host_model (
    input  wire logic         ref_clk,
    output coo_pkg::coo_req_t req
);
    import coo_pkg::*;
    initial req = '0;
    // Released address and data are inverted so that stale values cannot pass.
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge ref_clk);
        req <= '{w, ~w, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// *** hw/coo_charger_option_one.sv ***
// Charger option one register bank with its high-byte control decode.
`timescale 1ns/1ns
module coo_charger_option_one (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                clkEn,
    input  wire coo_pkg::coo_req_t   req,
    input  wire logic                lowPowerMode,
    input  wire logic                inputLimitPin,
    output logic [7:0]               rdData,
    output logic                     rdValid,
    output logic [15:0]              chargerOptionOne,
    output coo_pkg::coo_ctrl_t       ctrl
);
    import coo_pkg::*;

    logic [7:0]  optLow;
    logic [7:0]  optHigh;
    logic [7:0]  next_optLow;
    logic [7:0]  next_optHigh;
    logic [7:0]  next_rdData;
    logic        next_rdValid;
    coo_ctrl_t   next_ctrl;

    function automatic logic hot_decode(input logic [1:0] code);
        hot_decode = (code == HOT_VSYS);
    endfunction

    always_comb begin
        next_optLow  = optLow;
        next_optHigh = optHigh;
        next_rdData  = rdData;
        next_rdValid = 1'b0;
        if (req.wrEn) begin
            if (req.addr == OPT1_LOW_ADDR) begin
                next_optLow = req.wrData;
            end else if (req.addr == OPT1_HIGH_ADDR) begin
                next_optHigh = req.wrData;
            end
        end
        if (req.rdEn) begin
            next_rdValid = 1'b1;
            if (req.addr == OPT1_LOW_ADDR) begin
                next_rdData = optLow;
            end else if (req.addr == OPT1_HIGH_ADDR) begin
                next_rdData = optHigh;
            end else begin
                next_rdData = 8'h00;
            end
        end
    end

    always_comb begin
        next_ctrl.battCurrentBufferOn  = optHigh[BATT_BUF_BIT] & ~lowPowerMode;
        next_ctrl.sysPowerSenseOn      = optHigh[SYS_PWR_BIT] & ~lowPowerMode;
        next_ctrl.lowpowerHotMonitorOn = hot_decode(optHigh[HOT_SEL_HI:HOT_SEL_LO]);
        next_ctrl.inputSenseRes20m     = optHigh[IN_RES_BIT];
        next_ctrl.chargeSenseRes20m    = optHigh[CHG_RES_BIT];
        next_ctrl.sysPowerGainHigh     = optHigh[GAIN_BIT];
        next_ctrl.passThroughMode      = ~inputLimitPin & optHigh[LIMIT_FN_BIT];
        next_ctrl.highImpedanceMode    = ~inputLimitPin & ~optHigh[LIMIT_FN_BIT];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            optLow  <= OPT1_RESET[7:0];
            optHigh <= OPT1_RESET[15:8];
            rdData  <= 8'h00;
            rdValid <= 1'b0;
            ctrl    <= '0;
        end else if (clkEn) begin
            optLow  <= next_optLow;
            optHigh <= next_optHigh;
            rdData  <= next_rdData;
            rdValid <= next_rdValid;
            ctrl    <= next_ctrl;
        end
    end

    assign chargerOptionOne = {optHigh, optLow};

    a_reset_value: assert property (@(posedge ref_clk) $rose(rstn) |-> chargerOptionOne == OPT1_RESET)
        else $error("option register not at reset value");

    // Start conditions take the sampled reset, so the edge that releases reset starts no check built on these sequences.
    sequence s_live;
        rstn && clkEn;
    endsequence

    sequence s_frozen;
        rstn && !clkEn;
    endsequence

    sequence s_high_write;
        rstn && clkEn && req.wrEn && req.addr == OPT1_HIGH_ADDR;
    endsequence

    sequence s_low_write;
        rstn && clkEn && req.wrEn && req.addr == OPT1_LOW_ADDR;
    endsequence

    sequence s_stray_write;
        rstn && clkEn && req.wrEn && req.addr != OPT1_LOW_ADDR && req.addr != OPT1_HIGH_ADDR;
    endsequence

    sequence s_low_read;
        rstn && clkEn && req.rdEn && req.addr == OPT1_LOW_ADDR;
    endsequence

    sequence s_high_read;
        rstn && clkEn && req.rdEn && req.addr == OPT1_HIGH_ADDR;
    endsequence

    sequence s_stray_read;
        rstn && clkEn && req.rdEn && req.addr != OPT1_LOW_ADDR && req.addr != OPT1_HIGH_ADDR;
    endsequence

    sequence s_no_read;
        rstn && clkEn && !req.rdEn;
    endsequence

    sequence s_lpm_live;
        rstn && clkEn && lowPowerMode;
    endsequence

    sequence s_pin_idle;
        rstn && clkEn && inputLimitPin;
    endsequence

    sequence s_reserved_hot;
        rstn && clkEn && optHigh[HOT_SEL_LO];
    endsequence

    // A high-byte write reaches the controls after one more enabled edge.
    sequence s_high_settle;
        s_high_write ##1 s_live;
    endsequence

    a_reset_hold: assert property (@(posedge ref_clk)
        !rstn |=> chargerOptionOne == OPT1_RESET && !rdValid && ctrl == '0)
        else $error("state not at reset value during reset");

    a_batt_buf_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.battCurrentBufferOn == ($past(optHigh[BATT_BUF_BIT]) & ~$past(lowPowerMode)))
        else $error("battery buffer enable wrong");

    a_batt_free: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rstn && clkEn && !lowPowerMode && optHigh[BATT_BUF_BIT]) |=> ctrl.battCurrentBufferOn)
        else $error("battery buffer stayed off");

    a_batt_lpm_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_lpm_live |=> !ctrl.battCurrentBufferOn)
        else $error("battery buffer on in low power mode");

    a_hot_sel_map: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.lowpowerHotMonitorOn == ($past(optHigh[HOT_SEL_HI:HOT_SEL_LO]) == HOT_VSYS))
        else $error("hot monitor decode wrong");

    a_hot_on: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rstn && clkEn && optHigh[HOT_SEL_HI:HOT_SEL_LO] == HOT_VSYS) |=> ctrl.lowpowerHotMonitorOn)
        else $error("hot monitor not enabled");

    a_hot_low_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rstn && clkEn && optHigh[HOT_SEL_HI:HOT_SEL_LO] == HOT_OFF) |=> !ctrl.lowpowerHotMonitorOn)
        else $error("hot monitor on while disabled");

    a_sys_pwr_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.sysPowerSenseOn == ($past(optHigh[SYS_PWR_BIT]) & ~$past(lowPowerMode)))
        else $error("system power enable wrong");

    a_sys_free: assert property (@(posedge ref_clk) disable iff (!rstn)
        (rstn && clkEn && !lowPowerMode && optHigh[SYS_PWR_BIT]) |=> ctrl.sysPowerSenseOn)
        else $error("system power stayed off");

    a_sys_lpm_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_lpm_live |=> !ctrl.sysPowerSenseOn)
        else $error("system power on in low power mode");

    a_res_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.inputSenseRes20m == $past(optHigh[IN_RES_BIT]))
        else $error("input resistor select wrong");

    a_chg_res: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.chargeSenseRes20m == $past(optHigh[CHG_RES_BIT]))
        else $error("charge resistor select wrong");

    a_gain_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.sysPowerGainHigh == $past(optHigh[GAIN_BIT]))
        else $error("gain select wrong");

    a_limit_pin_fn: assert property (@(posedge ref_clk) disable iff (!rstn)
        ctrl.passThroughMode |-> !ctrl.highImpedanceMode)
        else $error("limit pin modes both active");

    a_limit_pass: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.passThroughMode == (!$past(inputLimitPin) && $past(optHigh[LIMIT_FN_BIT])))
        else $error("pass-through decode wrong");

    a_limit_hiz: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_live |=> ctrl.highImpedanceMode == (!$past(inputLimitPin) && !$past(optHigh[LIMIT_FN_BIT])))
        else $error("high impedance decode wrong");

    a_pin_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_pin_idle |=> !ctrl.passThroughMode && !ctrl.highImpedanceMode)
        else $error("limit pin mode without pin pulled low");

    a_hot_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_reserved_hot |=> !ctrl.lowpowerHotMonitorOn)
        else $error("reserved hot code enabled monitor");

    a_write_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_high_write |=> optHigh == $past(req.wrData))
        else $error("high byte write lost");

    a_write_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_low_write |=> optLow == $past(req.wrData))
        else $error("low byte write lost");

    a_stray_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_stray_write |=> $stable(chargerOptionOne))
        else $error("unmapped write changed register");

    // Reads return the value held before any write of the same cycle.
    a_read_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_low_read |=> rdValid && rdData == $past(optLow))
        else $error("low byte read wrong");

    a_read_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_high_read |=> rdValid && rdData == $past(optHigh))
        else $error("high byte read wrong");

    a_read_stray: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_stray_read |=> rdValid && rdData == 8'h00)
        else $error("unmapped read not zero");

    a_valid_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_no_read |=> !rdValid)
        else $error("read valid without read");

    a_read_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_no_read |=> $stable(rdData))
        else $error("read data changed without read");

    // With the clock enable low nothing may move.
    a_freeze_state: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_frozen |=> $stable(chargerOptionOne) && $stable(rdData) && $stable(rdValid))
        else $error("state moved while frozen");

    a_freeze_ctrl: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_frozen |=> $stable(ctrl))
        else $error("controls moved while frozen");

    property p_settle_batt;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.battCurrentBufferOn == ($past(req.wrData[BATT_BUF_BIT], 2) & ~$past(lowPowerMode));
    endproperty
    a_settle_batt: assert property (p_settle_batt)
        else $error("battery buffer not set by write");

    property p_settle_hot;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.lowpowerHotMonitorOn == ($past(req.wrData[HOT_SEL_HI:HOT_SEL_LO], 2) == HOT_VSYS);
    endproperty
    a_settle_hot: assert property (p_settle_hot)
        else $error("hot monitor not set by write");

    property p_settle_sys;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.sysPowerSenseOn == ($past(req.wrData[SYS_PWR_BIT], 2) & ~$past(lowPowerMode));
    endproperty
    a_settle_sys: assert property (p_settle_sys)
        else $error("system power not set by write");

    property p_settle_in_res;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.inputSenseRes20m == $past(req.wrData[IN_RES_BIT], 2);
    endproperty
    a_settle_in_res: assert property (p_settle_in_res)
        else $error("input resistor not set by write");

    property p_settle_chg_res;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.chargeSenseRes20m == $past(req.wrData[CHG_RES_BIT], 2);
    endproperty
    a_settle_chg_res: assert property (p_settle_chg_res)
        else $error("charge resistor not set by write");

    property p_settle_gain;
        @(posedge ref_clk) disable iff (!rstn)
        s_high_settle |=> ctrl.sysPowerGainHigh == $past(req.wrData[GAIN_BIT], 2);
    endproperty
    a_settle_gain: assert property (p_settle_gain)
        else $error("gain not set by write");

endmodule

// *** hw/coo_pkg.sv ***
// Package for the charger option one register bank: offsets, field layout, reset value and hot-select codes.
package coo_pkg;

    localparam logic [7:0]  OPT1_LOW_ADDR  = 8'h30;
    localparam logic [7:0]  OPT1_HIGH_ADDR = 8'h31;
    localparam logic [15:0] OPT1_RESET     = 16'h0211;

    localparam int BATT_BUF_BIT  = 7;
    localparam int HOT_SEL_HI    = 6;
    localparam int HOT_SEL_LO    = 5;
    localparam int SYS_PWR_BIT   = 4;
    localparam int IN_RES_BIT    = 3;
    localparam int CHG_RES_BIT   = 2;
    localparam int GAIN_BIT      = 1;
    localparam int LIMIT_FN_BIT  = 0;

    localparam logic [1:0] HOT_OFF  = 2'h0;
    localparam logic [1:0] HOT_VSYS = 2'h2;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } coo_req_t;

    typedef struct packed {
        logic       battCurrentBufferOn;
        logic       sysPowerSenseOn;
        logic       lowpowerHotMonitorOn;
        logic       inputSenseRes20m;
        logic       chargeSenseRes20m;
        logic       sysPowerGainHigh;
        logic       passThroughMode;
        logic       highImpedanceMode;
    } coo_ctrl_t;

endpackage
